// ==== common/fov_pkg.sv ====
// Shared constants and types for the upstream failover controller.
// Assumes a 125 MHz core clock and byte addresses on the register port.
package fov_pkg;
  // Register byte addresses
  localparam logic [11:0] OFS_STATUS = 12'h228;
  localparam logic [11:0] OFS_CONTROL = 12'h22C;
  localparam logic [11:0] OFS_TIMER = 12'h230;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h234;
  localparam logic [11:0] OFS_IRQ_CLEAR = 12'h238;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h23C;
  // Status field positions
  localparam int ST_MODE = 0;
  localparam int ST_DONE = 1;
  localparam int ST_START = 2;
  // Control field positions
  localparam int CT_SEL = 0;
  localparam int CT_SIG = 1;
  localparam int CT_TIM = 2;
  localparam int CT_SWAPDL = 3;
  localparam int CT_INDL = 4;
  localparam int CT_OUTDL = 5;
  localparam int CT_INPROP = 6;
  localparam int CT_OUTPROP = 7;
  localparam int CT_TOP = 7;
  // Interrupt bit positions
  localparam int IRQ_START = 0;
  localparam int IRQ_DONE = 1;
  // Boot switch modes that select the swapped association
  localparam logic [3:0] SWMODE_SWAP_LO = 4'h5;
  localparam logic [3:0] SWMODE_SWAP_HI = 4'h6;
  // Reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [31:0] TIMER_RESET = 32'h00000000;
  // Watchdog tick: one microsecond of core clock
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int PRE_W = 7;
  localparam logic [PRE_W-1:0] TICK_LAST = PRE_W'(TICK_CYCLES - 1);
  // Default length of one port swap in core cycles
  localparam logic [7:0] DEF_SWAP_CYCLES = 8'h10;

  typedef enum logic [1:0] {
    FS_BOOT = 2'b00,
    FS_IDLE = 2'b01,
    FS_SWAP = 2'b10
  } fov_state_type;

  // Sticky flag update: a set in the clearing cycle wins
  function automatic logic fov_sticky(input logic flag, input logic set, input logic clr);
    fov_sticky = set | (flag & ~clr);
  endfunction : fov_sticky
endpackage : fov_pkg

// ==== common/fov_wdog_if.sv ====
// Link between the failover controller and its watchdog counter.
// Assumes both ends share one clock.
interface fov_wdog_if;
  logic load;
  logic [31:0] load_val;
  logic [31:0] count;
  logic expire;
  modport ctrl (output load, output load_val, input count, input expire);
  modport wdog (input load, input load_val, output count, output expire);
endinterface : fov_wdog_if

// ==== design/fov_ctrl.sv ====
// Upstream port failover controller: registers, swap sequencing, interrupt.
// Assumes a 125 MHz core clock, synchronous inputs and a one-cycle
// strobed register port with read data in the following cycle.
module fov_ctrl
  import fov_pkg::*;
#(
  parameter logic [7:0] SWAP_CYCLES = DEF_SWAP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [11:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // Boot strap and swap request
  input wire logic [3:0] boot_switch_mode,
  input wire logic swap_request_input,
  // Hot reset causes
  input wire logic up_link_down,
  input wire logic br_link_down,
  input wire logic up_hot_rx,
  input wire logic br_hot_rx,
  // Gated hot resets
  output logic up_hot_reset,
  output logic br_hot_reset,
  // Port association and progress
  output logic current_port_mode,
  output logic swap_busy,
  // Interrupt
  output logic irq
);
  typedef struct packed {
    fov_state_type state;
    logic cur_mode;
    logic port_mode_select;
    logic target;
    logic [CT_TOP:1] ctl;
    logic mode_change_done;
    logic mode_change_started;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic [7:0] swap_cnt;
    logic [31:0] rd_data;
  } fov_ctrl_state_type;

  fov_ctrl_state_type r;
  fov_ctrl_state_type next_r;

  fov_wdog_if wd_if ();

  logic wr_status;
  logic wr_control;
  logic wr_irq_clear;
  logic wr_irq_enable;
  logic busy;
  logic sel_view;
  logic sw_go;
  logic sig_go;
  logic tim_go;
  logic go;
  logic go_mode;
  logic start_ev;
  logic done_ev;
  logic [CT_TOP:0] ctl_full;

  // Write decode
  assign wr_status = wr_en && (addr == OFS_STATUS);
  assign wr_control = wr_en && (addr == OFS_CONTROL);
  assign wr_irq_clear = wr_en && (addr == OFS_IRQ_CLEAR);
  assign wr_irq_enable = wr_en && (addr == OFS_IRQ_ENABLE);
  assign busy = (r.state == FS_SWAP);
  assign ctl_full = {r.ctl, sel_view};

  // Select reads the written value only while a swap is running
  assign sel_view = busy ? r.port_mode_select : r.cur_mode;

  // Swap triggers; a software write has priority over the others
  assign sw_go = wr_control && (wr_data[CT_SEL] != r.cur_mode);
  assign sig_go = r.ctl[CT_SIG] && (swap_request_input != r.cur_mode);
  assign tim_go = r.ctl[CT_TIM] && wd_if.expire;
  assign go = (r.state == FS_IDLE) && (sw_go || sig_go || tim_go);
  assign go_mode = sw_go ? wr_data[CT_SEL] : ~r.cur_mode;

  // Watchdog loads straight from the register port
  assign wd_if.load = wr_en && (addr == OFS_TIMER);
  assign wd_if.load_val = wr_data;

  // Next-state logic for the whole controller
  always_comb begin
    next_r = r;
    start_ev = 1'b0;
    done_ev = 1'b0;

    // Control writes; a select change mid-swap is not guarded
    if (wr_control) begin
      next_r.port_mode_select = wr_data[CT_SEL];
      next_r.ctl = wr_data[CT_TOP:1];
    end
    if (wr_irq_enable) begin
      next_r.irq_enable = wr_data[1:0];
    end

    // Swap sequencing
    case (r.state)
      FS_BOOT: begin
        // Strap is caught on the first edge after reset release
        next_r.cur_mode = (boot_switch_mode == SWMODE_SWAP_LO)
          || (boot_switch_mode == SWMODE_SWAP_HI);
        next_r.port_mode_select = next_r.cur_mode;
        next_r.target = next_r.cur_mode;
        next_r.state = FS_IDLE;
      end
      FS_IDLE: begin
        if (go) begin
          start_ev = 1'b1;
          next_r.target = go_mode;
          next_r.port_mode_select = go_mode;
          next_r.swap_cnt = SWAP_CYCLES - 8'h01;
          next_r.state = FS_SWAP;
        end
      end
      FS_SWAP: begin
        if (r.swap_cnt == 8'h00) begin
          done_ev = 1'b1;
          next_r.cur_mode = r.target;
          next_r.port_mode_select = r.target;
          next_r.state = FS_IDLE;
        end else begin
          next_r.swap_cnt = r.swap_cnt - 8'h01;
        end
      end
      default: begin
        next_r.state = FS_IDLE;
      end
    endcase

    // Sticky flags; hardware set beats a same-cycle clear
    next_r.mode_change_done = fov_sticky(r.mode_change_done, done_ev,
      wr_status && wr_data[ST_DONE]);
    next_r.mode_change_started = fov_sticky(r.mode_change_started, start_ev,
      wr_status && wr_data[ST_START]);
    next_r.irq_status[IRQ_START] = fov_sticky(r.irq_status[IRQ_START], start_ev,
      wr_irq_clear && wr_data[IRQ_START]);
    next_r.irq_status[IRQ_DONE] = fov_sticky(r.irq_status[IRQ_DONE], done_ev,
      wr_irq_clear && wr_data[IRQ_DONE]);

    // Read data stand only in the cycle after the strobe
    next_r.rd_data = 32'h00000000;
    if (rd_en) begin
      case (addr)
        OFS_STATUS: begin
          next_r.rd_data[ST_MODE] = r.cur_mode;
          next_r.rd_data[ST_DONE] = r.mode_change_done;
          next_r.rd_data[ST_START] = r.mode_change_started;
        end
        OFS_CONTROL: begin
          next_r.rd_data[CT_TOP:0] = ctl_full;
        end
        OFS_TIMER: begin
          next_r.rd_data = wd_if.count;
        end
        OFS_IRQ_STATUS: begin
          next_r.rd_data[1:0] = r.irq_status;
        end
        OFS_IRQ_ENABLE: begin
          next_r.rd_data[1:0] = r.irq_enable;
        end
        default: begin
          // Clear register and unmapped addresses read zero
          next_r.rd_data = 32'h00000000;
        end
      endcase
    end
  end

  // State register; rst is the fundamental reset, so sticky fields
  // are untouched by any hot reset this block gates
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '{state: FS_BOOT, cur_mode: 1'b0, port_mode_select: 1'b0,
             target: 1'b0, ctl: CTL_RESET[CT_TOP:1], mode_change_done: 1'b0,
             mode_change_started: 1'b0, irq_status: 2'b00, irq_enable: 2'b00,
             swap_cnt: 8'h00, rd_data: 32'h00000000};
    end else begin
      r <= next_r;
    end
  end

  // Watchdog counter
  fov_wdog u_wdog (
    .clk(clk),
    .rst(rst),
    .wd(wd_if.wdog)
  );

  // Hot reset gating follows the control bits live
  fov_hrst u_hrst (
    .clk(clk),
    .rst(rst),
    .ctl(ctl_full),
    .busy(busy),
    .up_link_down(up_link_down),
    .br_link_down(br_link_down),
    .up_hot_rx(up_hot_rx),
    .br_hot_rx(br_hot_rx),
    .up_hot_reset(up_hot_reset),
    .br_hot_reset(br_hot_reset)
  );

  // Outputs
  assign rd_data = r.rd_data;
  assign current_port_mode = r.cur_mode;
  assign swap_busy = busy;
  assign irq = |(r.irq_status & r.irq_enable);

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_swap_start;
    (r.state == FS_IDLE) && go;
  endsequence

  sequence s_swap_end;
    busy && (r.swap_cnt == 8'h00);
  endsequence

  property p_mode_read;
    (rd_en && addr == OFS_STATUS) |=> (rd_data[ST_MODE] == $past(r.cur_mode));
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("status mode bit wrong");

  property p_done;
    s_swap_end |=> (r.mode_change_done && !busy && r.cur_mode == $past(r.target));
  endproperty
  a_done: assert property (p_done)
    else $error("swap end not flagged");

  property p_started;
    s_swap_start |=> (r.mode_change_started && busy);
  endproperty
  a_started: assert property (p_started)
    else $error("swap start not flagged");

  property p_sw_write;
    ((r.state == FS_IDLE) && sw_go) |=> (busy && r.target == $past(wr_data[CT_SEL]));
  endproperty
  a_sw_write: assert property (p_sw_write)
    else $error("select write did not start swap");

  property p_sel_busy;
    (rd_en && addr == OFS_CONTROL && busy) |=>
      (rd_data[CT_SEL] == $past(r.port_mode_select));
  endproperty
  a_sel_busy: assert property (p_sel_busy)
    else $error("select read wrong during swap");

  property p_boot;
    (r.state == FS_BOOT) |=> (r.cur_mode == ($past(boot_switch_mode) == SWMODE_SWAP_LO
      || $past(boot_switch_mode) == SWMODE_SWAP_HI));
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot mode strap not applied");

  property p_signal;
    ((r.state == FS_IDLE) && r.ctl[CT_SIG] && swap_request_input != r.cur_mode)
      |=> busy ##[1:300] (r.cur_mode == $past(swap_request_input, 2));
  endproperty
  a_signal: assert property (p_signal)
    else $error("request input did not start swap");

  property p_timer;
    ((r.state == FS_IDLE) && r.ctl[CT_TIM] && wd_if.expire && !wr_control)
      |=> (busy && r.target != $past(r.cur_mode));
  endproperty
  a_timer: assert property (p_timer)
    else $error("watchdog expiry did not start swap");

  property p_reserved;
    // The watchdog count is a full 32-bit field, so it is left out here
    (rd_en && addr != OFS_TIMER) |=> (rd_data[31:8] == 24'h000000);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits not zero");
endmodule : fov_ctrl

// ==== design/fov_hrst.sv ====
// Hot reset gating for the upstream and bridge ports.
// Assumes event inputs are one-cycle pulses in the core clock domain.
module fov_hrst
  import fov_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic [CT_TOP:0] ctl,
  input wire logic busy,
  // Reset causes
  input wire logic up_link_down,
  input wire logic br_link_down,
  input wire logic up_hot_rx,
  input wire logic br_hot_rx,
  // Gated hot resets
  output logic up_hot_reset,
  output logic br_hot_reset
);
  typedef struct packed {
    logic up;
    logic br;
  } fov_hrst_state_type;

  fov_hrst_state_type r;
  fov_hrst_state_type next_r;
  logic swap_mask;

  // Link-down resets caused by a swap are masked only while one runs
  always_comb begin
    swap_mask = ctl[CT_SWAPDL] & busy;
    next_r.up = (up_link_down & ~ctl[CT_INDL] & ~swap_mask)
      | (up_hot_rx & ~ctl[CT_INPROP]);
    next_r.br = (br_link_down & ~ctl[CT_OUTDL] & ~swap_mask)
      | (br_hot_rx & ~ctl[CT_OUTPROP]);
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '{up: 1'b0, br: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign up_hot_reset = r.up;
  assign br_hot_reset = r.br;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_swap_dl_mask;
    (ctl[CT_SWAPDL] && busy && !up_hot_rx && !br_hot_rx) |=> (!up_hot_reset && !br_hot_reset);
  endproperty
  a_swap_dl_mask: assert property (p_swap_dl_mask)
    else $error("link-down reset leaked during swap");

  property p_up_prop;
    (up_hot_rx && !ctl[CT_INPROP]) |=> up_hot_reset;
  endproperty
  a_up_prop: assert property (p_up_prop)
    else $error("upstream hot reset lost");

  property p_br_mask;
    (!br_hot_rx && ctl[CT_OUTDL]) |=> !br_hot_reset;
  endproperty
  a_br_mask: assert property (p_br_mask)
    else $error("bridge link-down reset not masked");
endmodule : fov_hrst

// ==== design/fov_wdog.sv ====
// Microsecond watchdog counter for the failover controller.
// Assumes a 125 MHz clock; loads come from the register port.
module fov_wdog
  import fov_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Controller side
  fov_wdog_if.wdog wd
);
  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [31:0] count;
    logic expire;
  } fov_wdog_state_type;

  fov_wdog_state_type r;
  fov_wdog_state_type next_r;
  logic tick;

  // Prescale to microseconds and count down to zero
  always_comb begin
    next_r = r;
    tick = (r.pre == TICK_LAST);
    next_r.pre = tick ? '0 : r.pre + 1'b1;
    next_r.expire = 1'b0;
    if (wd.load) begin
      // Restart the prescaler so the first step is a full microsecond
      next_r.count = wd.load_val;
      next_r.pre = '0;
    end else if (tick && r.count != 32'h00000000) begin
      next_r.count = r.count - 32'h00000001;
      next_r.expire = (r.count == 32'h00000001);
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '{pre: '0, count: TIMER_RESET, expire: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign wd.count = r.count;
  assign wd.expire = r.expire;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_wdog_stops;
    (r.count == 32'h00000000 && !wd.load) |=> (r.count == 32'h00000000);
  endproperty
  a_wdog_stops: assert property (p_wdog_stops)
    else $error("watchdog moved below zero");

  property p_wdog_expire;
    wd.expire |-> (r.count == 32'h00000000 && $past(r.count) == 32'h00000001);
  endproperty
  a_wdog_expire: assert property (p_wdog_expire)
    else $error("expire without one-to-zero step");
endmodule : fov_wdog

// ==== tb/fov_ctrl_tb_top.sv ====
// Self-checking bench for the failover controller.
// Assumes the strobed register port and a 125 MHz clock.
module fov_ctrl_tb_top
  import fov_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} fov_row_type;
  logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, want = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wr_data = 32'h00000000, rd_data, rv;
  logic [3:0] boot_switch_mode = 4'h0, cause = 4'h0;
  logic [7:0] delay = 8'h00;
  logic swap_req, up_hot_reset, br_hot_reset, current_port_mode, swap_busy, irq;
  int miscompares = 0, n_checks = 0, cyc = 0, n;
  fov_row_type rows [11] = '{
    '{1'b0, 12'h230, 32'h0, 32'h0}, '{1'b0, 12'h228, 32'h0, 32'h0},
    '{1'b0, 12'h22C, 32'h0, 32'h0}, '{1'b1, 12'h22C, 32'hFFFFFFF8, 32'h0},
    '{1'b0, 12'h22C, 32'h0, 32'hF8}, '{1'b1, 12'h228, 32'hFFFFFFFF, 32'h0},
    '{1'b0, 12'h228, 32'h0, 32'h0}, '{1'b1, 12'h230, 32'h12345678, 32'h0},
    '{1'b0, 12'h230, 32'h0, 32'h12345678}, '{1'b0, 12'h240, 32'h0, 32'h0},
    '{1'b1, 12'h23C, 32'h3, 32'h0}};

  // Long swap so that reads and pulses fit inside it
  fov_ctrl #(.SWAP_CYCLES(8'h28)) fov_ctrl_inst (.clk(clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .boot_switch_mode(boot_switch_mode), .swap_request_input(swap_req),
    .up_link_down(cause[0]), .br_link_down(cause[1]), .up_hot_rx(cause[2]),
    .br_hot_rx(cause[3]), .up_hot_reset(up_hot_reset), .br_hot_reset(br_hot_reset),
    .current_port_mode(current_port_mode), .swap_busy(swap_busy), .irq(irq));
  fov_req_model fov_req_model_inst (.clk(clk), .rst(rst), .want_swapped(want),
    .delay(delay), .swap_request_input(swap_req));

  always #4 clk = ~clk;

  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One-cycle write strobe, released at the taking edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    rd(a, rv);
    chk(nm, rv, e);
  endtask : rdchk

  // One-cycle cause pulse; gated reset stands only in the cycle after the taking edge
  task automatic pulse(input logic [3:0] c);
    @(posedge clk);
    cause <= c;
    @(posedge clk);
    cause <= 4'h0;
    #1;
  endtask : pulse

  task automatic wait_busy(input logic lvl, input int lim);
    n = 0;
    while (swap_busy !== lvl && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    chk("busy wait", 32'(swap_busy), 32'(lvl));
  endtask : wait_busy

  task automatic do_reset(input logic [3:0] m);
    @(posedge clk);
    boot_switch_mode <= m;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : do_reset

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  initial begin
    do_reset(4'h0);
    // Register table rows: reset values, reserved bits, unmapped place
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rdchk("row", rows[i].a, rows[i].e);
    end
    $display("register rows done");
    // Software swap with swap-caused link-down masked
    wr(OFS_CONTROL, 32'h09);
    #1 chk("busy", 32'(swap_busy), 32'h1);
    rdchk("sel busy", OFS_CONTROL, 32'h09);
    pulse(4'h1);
    chk("up masked", 32'(up_hot_reset), 32'h0);
    rdchk("started", OFS_STATUS, 32'h4);
    // Mode takes the selected association only when the swap has ended
    wait_busy(1'b0, 60);
    chk("mode", 32'(current_port_mode), 32'h1);
    rdchk("done", OFS_STATUS, 32'h7);
    chk("irq", 32'(irq), 32'h1);
    wr(OFS_IRQ_ENABLE, 32'h0);
    #1 chk("irq mask", 32'(irq), 32'h0);
    wr(OFS_IRQ_ENABLE, 32'h1);
    wr(OFS_IRQ_CLEAR, 32'h1);
    #1 chk("irq clr", 32'(irq), 32'h0);
    rdchk("irq status", OFS_IRQ_STATUS, 32'h2);
    rdchk("irq enable", OFS_IRQ_ENABLE, 32'h1);
    wr(OFS_STATUS, 32'h6);
    rdchk("w1c", OFS_STATUS, 32'h1);
    $display("software swap done");
    // Mask bits 4 to 7 against each cause, mode held at one
    for (int b = 4; b < 8; b++) begin
      wr(OFS_CONTROL, 32'h1 | (32'h1 << b));
      for (int c = 0; c < 4; c++) begin
        pulse(4'h1 << c);
        chk("up rst", 32'(up_hot_reset), 32'(c == 0 && b != 4 || c == 2 && b != 6));
        chk("br rst", 32'(br_hot_reset), 32'(c == 1 && b != 5 || c == 3 && b != 7));
      end
    end
    $display("hot reset masks done");
    // Request level agrees first, then a slow change starts a swap
    want <= 1'b1;
    delay <= 8'h05;
    repeat (10) @(posedge clk);
    wr(OFS_CONTROL, 32'h03);
    repeat (5) @(posedge clk);
    #1 chk("no sig swap", 32'(swap_busy), 32'h0);
    want <= 1'b0;
    delay <= 8'h1E;
    wait_busy(1'b1, 60);
    wait_busy(1'b0, 60);
    chk("sig mode", 32'(current_port_mode), 32'h0);
    rdchk("sel idle", OFS_CONTROL, 32'h02);
    $display("signal swap done");
    // Expiry with the timer disabled changes nothing
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_TIMER, 32'h1);
    repeat (200) @(posedge clk);
    #1 chk("no tim swap", 32'(current_port_mode), 32'h0);
    rdchk("tim stop", OFS_TIMER, 32'h0);
    // Two microseconds then a swap on the one-to-zero step
    wr(OFS_CONTROL, 32'h04);
    wr(OFS_TIMER, 32'h2);
    wait_busy(1'b1, 400);
    chk("tim edges", 32'(n), 32'd251);
    wait_busy(1'b0, 60);
    chk("tim mode", 32'(current_port_mode), 32'h1);
    rdchk("tim zero", OFS_TIMER, 32'h0);
    $display("timer swap done");
    // Boot strap decides the starting association
    for (int m = 0; m < 16; m++) begin
      do_reset(4'(m));
      rdchk("boot sel", OFS_CONTROL, 32'(m == 5 || m == 6));
      chk("boot mode", 32'(current_port_mode), 32'(m == 5 || m == 6));
    end
    $display("boot modes done");
    final_report();
  end
endmodule : fov_ctrl_tb_top

// ==== tb/fov_req_model.sv ====
// Far-side model: system logic that drives the swap request level.
// Assumes the bench commands the wanted level and a settling delay.
module fov_req_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command from the bench
  input wire logic want_swapped,
  input wire logic [7:0] delay,
  // Request level toward the controller
  output logic swap_request_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_cnt;
  // High asks for swapped mode, low for normal; delay mimics a slow board
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swap_request_input <= 1'b0;
      wait_cnt <= 8'h00;
    end else if (want_swapped == swap_request_input) begin
      wait_cnt <= 8'h00;
    end else if (wait_cnt >= delay) begin
      swap_request_input <= want_swapped;
    end else begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end
endmodule : fov_req_model
